// *** src/i2cbc_pkg.sv ***
/*
 * i2cbc_pkg: register map, field positions, reset values, state encoding
 * and carrier types for the multi-master bus-collision aware master port.
 * Assumes a single 200 MHz system clock and an 8-bit register port.
 */
package i2cbc_pkg;

   // ********************************************************************
   // register map (word index on the plain register port)
   // ********************************************************************
   localparam int ADDR_W = 3;
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_BAUD = 3'h1;
   localparam logic [2:0] REG_CTRL = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam logic [2:0] REG_FLAGS = 3'h4;
   localparam logic [2:0] REG_IRQEN = 3'h5;
   localparam logic [2:0] REG_PRIO = 3'h6;

   // ********************************************************************
   // field positions
   // ********************************************************************
   localparam int CTL_START = 0;
   localparam int CTL_RSTART = 1;
   localparam int CTL_STOP = 2;
   localparam int CTL_ACK = 4;
   localparam int CTL_ACKDT = 5;
   localparam int CTL_ACKSTAT = 6;
   localparam int STA_BF = 0;
   localparam int STA_START = 3;
   localparam int STA_STOP = 4;
   localparam int FLG_PORT = 0;
   localparam int FLG_COLL = 1;
   localparam int REQ_START = 0;
   localparam int REQ_RSTART = 1;
   localparam int REQ_STOP = 2;
   localparam int REQ_ACK = 3;

   // ********************************************************************
   // reset values and counts
   // ********************************************************************
   localparam logic [7:0] BAUD_RST = 8'h09;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [1:0] FLAGS_RST = 2'h0;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_SLOT = 4'h8;

   // gray codes along start, repeated start and stop paths and within one bit (low, rise, high)
   typedef enum logic [3:0] {
      S_IDLE    = 4'h0,
      S_ST_HOLD = 4'h1,
      S_ST_LOW  = 4'h3,
      S_RS_SDA  = 4'h2,
      S_RS_SCLR = 4'h6,
      S_RS_HOLD = 4'h7,
      S_RS_LOW  = 4'h5,
      S_SP_SDA  = 4'h4,
      S_SP_SCLR = 4'hc,
      S_SP_HOLD = 4'hd,
      S_SP_CHK  = 4'hf,
      S_B_LOW   = 4'he,
      S_B_RISE  = 4'ha,
      S_B_HIGH  = 4'hb
   } i2cbc_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cbc_lines_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } i2cbc_req_t;

endpackage : i2cbc_pkg

// *** src/i2cbc_master.sv ***
/*
 * i2cbc_master: two-wire master port with multi-master arbitration and
 * bus-collision detection, plain register port and two interrupt levels.
 * Assumes open-drain pads outside (oe_n low pulls the line low) and that
 * scl_i/sda_i are asynchronous to sys_clk_i.
 */
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module i2cbc_master
   import i2cbc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // register port
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // interrupt
   output logic irq_o,
   output logic irq_high_o,
   // bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);

   // ********************************************************************
   // pin synchronisers and bus condition detect
   // ********************************************************************
   i2cbc_lines_t line_s1_reg;
   i2cbc_lines_t line_s2_reg;
   i2cbc_lines_t line_d_reg;
   i2cbc_lines_t lin;
   i2cbc_req_t bus;
   logic bus_start;
   logic bus_stop;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         line_s1_reg <= '1;
         line_s2_reg <= '1;
         line_d_reg <= '1;
      end else begin
         line_s1_reg <= '{scl: scl_i, sda: sda_i};
         line_s2_reg <= line_s1_reg;
         line_d_reg <= line_s2_reg;
      end
   end

   assign lin = line_s2_reg;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
   assign bus_start = line_d_reg.scl & lin.scl & line_d_reg.sda & ~lin.sda;
   assign bus_stop = line_d_reg.scl & lin.scl & ~line_d_reg.sda & lin.sda;

   // ********************************************************************
   // state and registers
   // ********************************************************************
   i2cbc_state_t st_reg;
   i2cbc_state_t st_next;
   logic scl_oe_n_reg;
   logic scl_oe_n_next;
   logic sda_oe_n_reg;
   logic sda_oe_n_next;
   logic pin_low_reg;
   logic [7:0] baud_reg;
   logic [7:0] brg_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_reg;
   logic [3:0] req_reg;
   logic [3:0] req_first;
   logic ack_seq_reg;
   logic ack_dt_reg;
   logic ack_stat_reg;
   logic bf_reg;
   logic coll_wait_reg;
   logic start_seen_reg;
   logic stop_seen_reg;
   logic [1:0] flags_reg;
   logic [1:0] flags_next;
   logic [1:0] irqen_reg;
   logic [1:0] prio_reg;
   logic [7:0] rdata_reg;
   logic irq_reg;
   logic irq_high_reg;

   // ********************************************************************
   // decode
   // ********************************************************************
   logic idle;
   logic brg_zero;
   logic wr_data;
   logic wr_ctrl;
   logic rd_flags;
   logic listen_slot;
   logic last_bit;
   logic next_bit_one;
   logic [7:0] rd_mux;
   logic [7:0] ctrl_view;
   logic [7:0] stat_view;

   assign idle = (st_reg == S_IDLE);
   assign brg_zero = (brg_reg == ZERO_BYTE);
   // busy writes are dropped; after a collision the port is idle again
   assign wr_data = bus.wr && (bus.addr == REG_DATA) && idle && !bf_reg;
   assign wr_ctrl = bus.wr && (bus.addr == REG_CTRL) && idle;
   assign rd_flags = bus.rd && (bus.addr == REG_FLAGS);
   assign listen_slot = (bit_reg == BIT_SLOT) && !ack_seq_reg;
   assign last_bit = (bit_reg == BIT_SLOT);
   // the bit after the eighth is the listen slot, so data is released
   assign next_bit_one = (bit_reg == 4'h7) ? 1'b1 : shift_reg[6];
   assign req_first = req_reg & (~req_reg + 4'h1);
   assign ctrl_view = {1'b0, ack_stat_reg, ack_dt_reg, req_reg[REQ_ACK], 1'b0,
                       req_reg[REQ_STOP], req_reg[REQ_RSTART], req_reg[REQ_START]};
   assign stat_view = {3'h0, stop_seen_reg, start_seen_reg, 2'h0, bf_reg};
   assign rd_mux = (bus.addr == REG_DATA) ? shift_reg :
                   (bus.addr == REG_BAUD) ? baud_reg :
                   (bus.addr == REG_CTRL) ? ctrl_view :
                   (bus.addr == REG_STAT) ? stat_view :
                   (bus.addr == REG_FLAGS) ? {6'h00, flags_reg} :
                   (bus.addr == REG_IRQEN) ? {6'h00, irqen_reg} :
                   (bus.addr == REG_PRIO) ? {6'h00, prio_reg} : ZERO_BYTE;

   // ********************************************************************
   // sequence engine
   // ********************************************************************
   logic brg_load;
   logic coll_evt;
   logic seq_done;
   logic tx_done;
   logic stop_ok;
   logic bit_step;
   logic ack_go;

   always_comb begin
      st_next = st_reg;
      scl_oe_n_next = scl_oe_n_reg;
      sda_oe_n_next = sda_oe_n_reg;
      brg_load = 1'b0;
      coll_evt = 1'b0;
      seq_done = 1'b0;
      tx_done = 1'b0;
      stop_ok = 1'b0;
      bit_step = 1'b0;
      ack_go = 1'b0;
      case (st_reg)
         S_IDLE: begin
            if (req_reg[REQ_START]) begin
               if (!lin.scl || !lin.sda) begin
                  coll_evt = 1'b1;
               end else begin
                  brg_load = 1'b1;
                  st_next = S_ST_HOLD;
               end
            end else if (req_reg[REQ_RSTART]) begin
               sda_oe_n_next = 1'b1;
               brg_load = 1'b1;
               st_next = S_RS_SDA;
            end else if (req_reg[REQ_STOP]) begin
               sda_oe_n_next = 1'b0;
               scl_oe_n_next = 1'b0;
               brg_load = 1'b1;
               st_next = S_SP_SDA;
            end else if (req_reg[REQ_ACK]) begin
               ack_go = 1'b1;
               scl_oe_n_next = 1'b0;
               sda_oe_n_next = ack_dt_reg;
               brg_load = 1'b1;
               st_next = S_B_LOW;
            end else if (bf_reg) begin
               scl_oe_n_next = 1'b0;
               sda_oe_n_next = shift_reg[7];
               brg_load = 1'b1;
               st_next = S_B_LOW;
            end
         end
         S_ST_HOLD: begin
            if (!lin.sda) begin
               sda_oe_n_next = 1'b0;
               brg_load = 1'b1;
               st_next = S_ST_LOW;
            end else if (!lin.scl) begin
               coll_evt = 1'b1;
            end else if (brg_zero) begin
               sda_oe_n_next = 1'b0;
               brg_load = 1'b1;
               st_next = S_ST_LOW;
            end
         end
         S_ST_LOW: begin
            // another master pulling the clock here is not a collision
            if (brg_zero) begin
               scl_oe_n_next = 1'b0;
               seq_done = 1'b1;
               st_next = S_IDLE;
            end
         end
         S_RS_SDA: begin
            if (brg_zero) begin
               scl_oe_n_next = 1'b1;
               st_next = S_RS_SCLR;
            end
         end
         S_RS_SCLR: begin
            if (lin.scl) begin
               if (!lin.sda) begin
                  coll_evt = 1'b1;
               end else begin
                  brg_load = 1'b1;
                  st_next = S_RS_HOLD;
               end
            end
         end
         S_RS_HOLD: begin
            if (!lin.sda || brg_zero) begin
               sda_oe_n_next = 1'b0;
               brg_load = 1'b1;
               st_next = S_RS_LOW;
            end else if (!lin.scl) begin
               coll_evt = 1'b1;
            end
         end
         S_RS_LOW: begin
            if (brg_zero) begin
               scl_oe_n_next = 1'b0;
               seq_done = 1'b1;
               st_next = S_IDLE;
            end
         end
         S_SP_SDA: begin
            if (brg_zero) begin
               scl_oe_n_next = 1'b1;
               st_next = S_SP_SCLR;
            end
         end
         S_SP_SCLR: begin
            if (lin.scl) begin
               brg_load = 1'b1;
               st_next = S_SP_HOLD;
            end
         end
         S_SP_HOLD: begin
            if (!lin.scl) begin
               coll_evt = 1'b1;
            end else if (brg_zero) begin
               sda_oe_n_next = 1'b1;
               brg_load = 1'b1;
               st_next = S_SP_CHK;
            end
         end
         S_SP_CHK: begin
            if (brg_zero) begin
               if (!lin.sda) begin
                  coll_evt = 1'b1;
               end else begin
                  stop_ok = 1'b1;
                  seq_done = 1'b1;
                  st_next = S_IDLE;
               end
            end
         end
         S_B_LOW: begin
            if (brg_zero) begin
               scl_oe_n_next = 1'b1;
               st_next = S_B_RISE;
            end
         end
         S_B_RISE: begin
            // clock stretching: wait until the line really is high
            if (lin.scl) begin
               brg_load = 1'b1;
               st_next = S_B_HIGH;
            end
         end
         S_B_HIGH: begin
            if (sda_oe_n_reg && !listen_slot && !lin.sda) begin
               coll_evt = 1'b1;
            end else if (brg_zero) begin
               scl_oe_n_next = 1'b0;
               if (last_bit) begin
                  tx_done = !ack_seq_reg;
                  seq_done = ack_seq_reg;
                  st_next = S_IDLE;
               end else begin
                  bit_step = 1'b1;
                  sda_oe_n_next = next_bit_one;
                  brg_load = 1'b1;
                  st_next = S_B_LOW;
               end
            end
         end
         default: begin
            st_next = S_IDLE;
         end
      endcase
      if (coll_evt) begin
         st_next = S_IDLE;
         scl_oe_n_next = 1'b1;
         sda_oe_n_next = 1'b1;
         brg_load = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= S_IDLE;
         scl_oe_n_reg <= 1'b1;
         sda_oe_n_reg <= 1'b1;
         pin_low_reg <= 1'b0;
         brg_reg <= ZERO_BYTE;
      end else begin
         st_reg <= st_next;
         scl_oe_n_reg <= scl_oe_n_next;
         sda_oe_n_reg <= sda_oe_n_next;
         pin_low_reg <= 1'b0;
         if (brg_load) begin
            brg_reg <= baud_reg;
         end else if (!brg_zero) begin
            brg_reg <= brg_reg - 8'h01;
         end
      end
   end

   // ********************************************************************
   // data path and control bits
   // ********************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_reg <= ZERO_BYTE;
         bit_reg <= BIT_FIRST;
         ack_seq_reg <= 1'b0;
         bf_reg <= 1'b0;
         ack_stat_reg <= 1'b0;
      end else begin
         if (wr_data) begin
            shift_reg <= bus.wdata;
            bit_reg <= BIT_FIRST;
            ack_seq_reg <= 1'b0;
         end else if (ack_go) begin
            bit_reg <= BIT_SLOT;
            ack_seq_reg <= 1'b1;
         end else if (bit_step) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 4'h1;
         end
         if (coll_evt || tx_done) begin
            bf_reg <= 1'b0;
         end else if (wr_data) begin
            bf_reg <= 1'b1;
         end
         if (tx_done) begin
            ack_stat_reg <= lin.sda;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_reg <= 4'h0;
         ack_dt_reg <= 1'b0;
         baud_reg <= BAUD_RST;
      end else begin
         if (coll_evt) begin
            req_reg <= 4'h0;
         end else if (seq_done) begin
            req_reg <= req_reg & ~req_first;
         end else if (wr_ctrl) begin
            req_reg <= req_reg | {bus.wdata[CTL_ACK], bus.wdata[CTL_STOP],
                                  bus.wdata[CTL_RSTART], bus.wdata[CTL_START]};
         end
         if (wr_ctrl) begin
            ack_dt_reg <= bus.wdata[CTL_ACKDT];
         end
         if (bus.wr && bus.addr == REG_BAUD) begin
            baud_reg <= bus.wdata;
         end
      end
   end

   // ********************************************************************
   // bus watch, flags and interrupt
   // ********************************************************************
   always_comb begin
      flags_next = flags_reg & ~(rd_flags ? 2'h3 : 2'h0);
      // set wins over the read clear in the same cycle
      if (coll_evt) begin
         flags_next[FLG_COLL] = 1'b1;
      end
      if (tx_done || seq_done || (bus_stop && coll_wait_reg)) begin
         flags_next[FLG_PORT] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_reg <= FLAGS_RST;
         irqen_reg <= FLAGS_RST;
         prio_reg <= FLAGS_RST;
         coll_wait_reg <= 1'b0;
         start_seen_reg <= 1'b0;
         stop_seen_reg <= 1'b0;
         rdata_reg <= ZERO_BYTE;
         irq_reg <= 1'b0;
         irq_high_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         if (bus.wr && bus.addr == REG_IRQEN) begin
            irqen_reg <= bus.wdata[1:0];
         end
         if (bus.wr && bus.addr == REG_PRIO) begin
            prio_reg <= bus.wdata[1:0];
         end
         if (coll_evt) begin
            coll_wait_reg <= 1'b1;
         end else if (bus_stop || (idle && req_reg[REQ_START])) begin
            coll_wait_reg <= 1'b0;
         end
         // software polls these before retaking the bus
         if (bus_start) begin
            start_seen_reg <= 1'b1;
            stop_seen_reg <= 1'b0;
         end else if (bus_stop) begin
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b1;
         end
         rdata_reg <= bus.rd ? rd_mux : ZERO_BYTE;
         irq_reg <= |(flags_next & irqen_reg);
         irq_high_reg <= |(flags_next & irqen_reg & prio_reg);
      end
   end

   assign rdata_o = rdata_reg;
   assign irq_o = irq_reg;
   assign irq_high_o = irq_high_reg;
   assign scl_o = pin_low_reg;
   assign sda_o = pin_low_reg;
   assign scl_oe_n_o = scl_oe_n_reg;
   assign sda_oe_n_o = sda_oe_n_reg;

   // ********************************************************************
   // checks
   // ********************************************************************
   a_bit_arbitration: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg == S_B_HIGH && sda_oe_n_reg && !listen_slot && !lin.sda)
      |=> st_reg == S_IDLE && flags_reg[FLG_COLL])
      else $error("bit arbitration loss not caught");
   a_coll_halts_tx: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      coll_evt |=> !bf_reg && scl_oe_n_o && sda_oe_n_o)
      else $error("collision did not halt transfer");
   a_coll_clr_req: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      coll_evt |=> req_reg == 4'h0 ##1 st_reg == S_IDLE)
      else $error("collision left a request pending");
   a_stop_after_coll: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (bus_stop && coll_wait_reg && !coll_evt) |=> flags_reg[FLG_PORT] && !coll_wait_reg)
      else $error("bus stop after collision not flagged");
   a_restart_first_bit: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      wr_data |=> bit_reg == BIT_FIRST && shift_reg == $past(bus.wdata) && bf_reg)
      else $error("data write did not restart at first bit");
   a_start_busy: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (idle && req_reg[REQ_START] && !(lin.scl && lin.sda))
      |=> flags_reg[FLG_COLL] && idle && !req_reg[REQ_START])
      else $error("start on busy bus not aborted");
   a_start_early: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg == S_ST_HOLD && !lin.sda)
      |=> st_reg == S_ST_LOW && !sda_oe_n_o && brg_reg == baud_reg)
      else $error("start did not pull data early");
   a_rs_clock_loss: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg == S_RS_HOLD && lin.sda && !lin.scl && !brg_zero)
      |=> st_reg == S_IDLE && flags_reg[FLG_COLL])
      else $error("repeated start clock loss not caught");
   a_stop_clock_loss: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (st_reg == S_SP_HOLD && !lin.scl) |=> st_reg == S_IDLE && sda_oe_n_o)
      else $error("stop clock loss not caught");
   a_reload_value: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      brg_load |=> brg_reg == $past(baud_reg))
      else $error("counter not loaded from reload value");
   a_irq_level: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      (flags_reg[FLG_COLL] && irqen_reg[FLG_COLL]) |-> irq_o)
      else $error("enabled collision flag did not interrupt");

endmodule : i2cbc_master

// *** test/i2cbc_peer.sv ***
/* i2cbc_peer: a second bus party that can hold either line low.
   Assumes open-drain wires, pull-ups outside; 1 = line released. */
`timescale 1ns/1ps
module i2cbc_peer (
   // link side
   input wire logic link_clk_i,
   input wire logic hold_sda_i,
   input wire logic hold_scl_i,
   // open-drain releases
   output logic sda_rel_o,
   output logic scl_rel_o
);
   logic [1:0] hold_reg = 2'h0;
   // moves on its own clock, so pulls land at any phase of the master's
   always_ff @(posedge link_clk_i) begin
      hold_reg <= {hold_scl_i, hold_sda_i};
   end
   assign scl_rel_o = ~hold_reg[1];
   assign sda_rel_o = ~hold_reg[0];
endmodule : i2cbc_peer

// *** test/i2c_master_bus_collision_tb.sv ***
/* i2c_master_bus_collision_tb: directed collision scenarios with a peer.
   Assumes wires are the AND of all pullers and a 200 MHz system clock. */
`timescale 1ns/1ps
module i2c_master_bus_collision_tb;
   import i2cbc_pkg::*;
   logic sys_clk_i = 1'b0;
   logic link_clk = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic hold_sda = 1'b0;
   logic hold_scl = 1'b0;
   logic [7:0] rdata_o;
   logic irq_o, irq_high_o, scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, sda_rel, scl_rel;
   int err_total = 0;
   int comparisons = 0;
   wire logic scl_line = scl_oe_n_o & scl_rel;
   wire logic sda_line = sda_oe_n_o & sda_rel;

   i2cbc_master i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
      .irq_high_o(irq_high_o), .scl_i(scl_line), .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
   i2cbc_peer i_peer (.link_clk_i(link_clk), .hold_sda_i(hold_sda),
      .hold_scl_i(hold_scl), .sda_rel_o(sda_rel), .scl_rel_o(scl_rel));

   initial forever #2.5 sys_clk_i = ~sys_clk_i;
   initial begin
      #7;
      forever #32 link_clk = ~link_clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : rchk

   // bounded wait for the collision interrupt or for the clock pull
   task automatic wait_for(input logic on_irq);
      int n;
      n = 0;
      while (((on_irq ? irq_o : ~scl_oe_n_o) !== 1'b1) && n < 2000) begin
         @(posedge sys_clk_i);
         n++;
      end
      // a wait that runs out counts as a mismatch
      if (n >= 2000) begin
         err_total++;
      end
      #1;
   endtask : wait_for

   task automatic settle;
      repeat (30) @(posedge sys_clk_i);
   endtask : settle

   task automatic t_reset;
      rchk(REG_BAUD, BAUD_RST);
      rchk(REG_FLAGS, ZERO_BYTE);
      chk({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      chk({6'h00, scl_o, sda_o}, 8'h00);
   endtask : t_reset

   task automatic t_start_low;
      wr(REG_IRQEN, 8'h02);
      wr(REG_PRIO, 8'h02);
      hold_sda <= 1'b1;
      settle();
      wr(REG_CTRL, 8'h01);
      repeat (8) @(posedge sys_clk_i);
      chk({6'h00, irq_o, irq_high_o}, 8'h03);
      chk({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      rchk(REG_CTRL, ZERO_BYTE);
      rchk(REG_FLAGS, 8'h02);
      hold_sda <= 1'b0;
      settle();
      chk({7'h00, irq_o}, 8'h00);
      rchk(REG_FLAGS, 8'h01);
   endtask : t_start_low

   task automatic t_start_scl;
      wr(REG_BAUD, 8'h30);
      wr(REG_CTRL, 8'h01);
      hold_scl <= 1'b1;
      repeat (40) @(posedge sys_clk_i);
      rchk(REG_FLAGS, 8'h02);
      rchk(REG_CTRL, ZERO_BYTE);
      hold_scl <= 1'b0;
      // peer lets go only on its own clock edge
      settle();
      wr(REG_BAUD, 8'h05);
   endtask : t_start_scl

   task automatic t_byte;
      // stop seen on the bus, so the bus may be taken
      rchk(REG_STAT, 8'h10);
      wr(REG_CTRL, 8'h01);
      wait_for(1'b0);
      chk({7'h00, sda_oe_n_o}, 8'h00);
      rchk(REG_FLAGS, 8'h01);
      wr(REG_DATA, 8'h55);
      hold_sda <= 1'b1;
      wait_for(1'b1);
      chk({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      rchk(REG_STAT, 8'h08);
      rchk(REG_FLAGS, 8'h02);
      hold_sda <= 1'b0;
      settle();
      rchk(REG_FLAGS, 8'h01);
      wr(REG_CTRL, 8'h01);
      wait_for(1'b0);
      wr(REG_DATA, 8'h80);
      repeat (3) @(posedge sys_clk_i);
      chk({7'h00, sda_oe_n_o}, 8'h01);
      repeat (200) @(posedge sys_clk_i);
      rchk(REG_STAT, 8'h08);
      rchk(REG_CTRL, 8'h40);
      rchk(REG_FLAGS, 8'h01);
      wr(REG_CTRL, 8'h04);
      repeat (40) @(posedge sys_clk_i);
      rchk(REG_FLAGS, 8'h01);
      rchk(REG_STAT, 8'h10);
      chk({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h03);
   endtask : t_byte

   // peer pulls data during the long start count: data must follow at once
   task automatic t_start_early;
      wr(REG_BAUD, 8'h30);
      wr(REG_CTRL, 8'h01);
      hold_sda <= 1'b1;
      repeat (30) @(posedge sys_clk_i);
      chk({6'h00, scl_oe_n_o, sda_oe_n_o}, 8'h02);
      wait_for(1'b0);
      rchk(REG_FLAGS, 8'h01);
      hold_sda <= 1'b0;
   endtask : t_start_early

   task automatic final_report;
      $display("Checks: %0d, errors: %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_start_low();
      t_start_scl();
      t_byte();
      t_start_early();
      final_report();
   end

   // the scenarios need well under a tenth of this span
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      err_total++;
      final_report();
   end
endmodule : i2c_master_bus_collision_tb
